// *** shared/dspdec_pkg.sv ***
package dspdec_pkg;

    ////////////////////////////////////////////////////////////////
    // Widths
    localparam int WORD_W = 16;
    localparam int SHIFT_W = 5;
    localparam int FLAG_N = 7;

    ////////////////////////////////////////////////////////////////
    // Decoded operations
    typedef enum logic [4:0] {
        OP_NONE = 5'h00,
        OP_POP_TO_ACC = 5'h01,
        OP_PUSH_FROM_ACC = 5'h02,
        OP_STACK_TO_MEMORY = 5'h03,
        OP_MEMORY_TO_STACK = 5'h04,
        OP_CONDITIONAL_RETURN = 5'h05,
        OP_REPEAT_NEXT_IMM = 5'h06,
        OP_REPEAT_NEXT_MEM = 5'h07,
        OP_STORE_UPPER_ACC_SHIFTED = 5'h08,
        OP_STORE_LOWER_ACC_SHIFTED = 5'h09,
        OP_AUX_REG_SUBTRACT_IMM = 5'h0a,
        OP_FLAG_SET_GROUP = 5'h0b,
        OP_SQUARE_ACCUMULATE = 5'h0c,
        OP_SQUARE_SUBTRACT = 5'h0d,
        OP_STORE_LONG_CONSTANT = 5'h0e,
        OP_ACC_SUBTRACT_LONG = 5'h0f,
        OP_ACC_SUBTRACT_SHIFT = 5'h10,
        OP_ACC_SUBTRACT_BORROW = 5'h11,
        OP_ACC_SUBTRACT_UNSIGNED = 5'h12,
        OP_ACC_SUBTRACT_TEMP_SHIFT = 5'h13,
        OP_XOR_LONG_SHIFT = 5'h14,
        OP_XOR_LONG_SHIFT16 = 5'h15,
        OP_CLEAR_LOAD_ROUND = 5'h16,
        OP_STATUS_STORE_ZERO = 5'h17,
        OP_STATUS_STORE_ONE = 5'h18,
        OP_PRODUCT_SHIFT_MODE_SET = 5'h19
    } dspdec_op_e;

    ////////////////////////////////////////////////////////////////
    // Sequencer states
    typedef enum logic [1:0] {
        ST_OPCODE = 2'b01,
        ST_CONST = 2'b10
    } dspdec_state_e;

    ////////////////////////////////////////////////////////////////
    // Word and cycle counts
    localparam logic [1:0] WORDS_ONE = 2'h1;
    localparam logic [1:0] WORDS_TWO = 2'h2;
    localparam logic [2:0] CYC_ONE = 3'h1;
    localparam logic [2:0] CYC_TWO = 3'h2;
    localparam logic [2:0] CYC_RET_TAKEN = 3'h4;
    localparam logic [2:0] CYC_RET_SKIP = 3'h2;

    ////////////////////////////////////////////////////////////////
    // Encodings
    localparam logic [15:0] ENC_POP = 16'hbe32;
    localparam logic [15:0] ENC_PUSH = 16'hbe3c;
    localparam logic [15:0] ENC_XOR16 = 16'hbe83;
    localparam logic [11:0] PFX_FLAG = 12'hbe4;
    localparam logic [11:0] PFX_SUB_LONG = 12'hbfa;
    localparam logic [11:0] PFX_XOR_LONG = 12'hbfd;
    localparam logic [7:0] UB_STACK_TO_MEM = 8'h8a;
    localparam logic [7:0] UB_MEM_TO_STACK = 8'h76;
    localparam logic [7:0] UB_RPT_IMM = 8'hbb;
    localparam logic [7:0] UB_RPT_MEM = 8'h0b;
    localparam logic [7:0] UB_AUX_SUB = 8'h7c;
    localparam logic [7:0] UB_SQR_ACC = 8'h52;
    localparam logic [7:0] UB_SQR_SUB = 8'h53;
    localparam logic [7:0] UB_STORE_LONG = 8'hae;
    localparam logic [7:0] UB_SUB_BORROW = 8'h64;
    localparam logic [7:0] UB_SUB_UNSIGNED = 8'h66;
    localparam logic [7:0] UB_SUB_TEMP = 8'h67;
    localparam logic [7:0] UB_CLR_LOAD_RND = 8'h68;
    localparam logic [7:0] UB_STATUS_ZERO = 8'h8e;
    localparam logic [7:0] UB_STATUS_ONE = 8'h8f;
    localparam logic [7:0] UB_PSHIFT_MODE = 8'hbf;
    localparam logic [5:0] TOP6_COND_RET = 6'h3b;
    localparam logic [3:0] NIB_STORE_ACC = 4'h9;
    localparam logic [3:0] NIB_SUB_SHIFT = 4'h3;
    localparam logic [4:0] SHIFT_XOR16 = 5'h10;

    ////////////////////////////////////////////////////////////////
    // Flag nibbles and flag output bit positions
    localparam logic [3:0] FNIB_CARRY = 4'hf;
    localparam logic [3:0] FNIB_BLOCK_PROG = 4'h5;
    localparam logic [3:0] FNIB_INT_DISABLE = 4'h1;
    localparam logic [3:0] FNIB_OVF_MODE = 4'h3;
    localparam logic [3:0] FNIB_TEST_CTRL = 4'hb;
    localparam logic [3:0] FNIB_EXT_FLAG = 4'hd;
    localparam logic [3:0] FNIB_SIGN_EXT = 4'h7;
    localparam int FBIT_CARRY = 0;
    localparam int FBIT_BLOCK_PROG = 1;
    localparam int FBIT_INT_DISABLE = 2;
    localparam int FBIT_OVF_MODE = 3;
    localparam int FBIT_TEST_CTRL = 4;
    localparam int FBIT_EXT_FLAG = 5;
    localparam int FBIT_SIGN_EXT = 6;

    ////////////////////////////////////////////////////////////////
    // Field positions
    localparam int FLD_ADDR_LSB = 0;
    localparam int FLD_ADDR_MSB = 7;
    localparam int FLD_SHIFT4_LSB = 8;
    localparam int FLD_SHIFT4_MSB = 11;
    localparam int FLD_SHIFT3_MSB = 10;
    localparam int FLD_HALF_BIT = 11;
    localparam int FLD_TP_LSB = 8;
    localparam int FLD_TP_MSB = 9;
    localparam int FLD_LOWNIB_MSB = 3;

endpackage

// *** shared/dspdec_field_if.sv ***
`timescale 1ns/10ps

interface dspdec_field_if;
    logic [15:0] word;
    logic [7:0] addr;
    logic [7:0] upper_byte;
    logic [11:0] prefix12;
    logic [5:0] top6;
    logic [3:0] top_nib;
    logic [3:0] low_nib;
    logic [3:0] shift4;
    logic [2:0] shift3;
    logic upper_half;
    logic [1:0] tp;

    modport core (
        output word,
        input addr, upper_byte, prefix12, top6, top_nib, low_nib,
        input shift4, shift3, upper_half, tp
    );

    modport split (
        input word,
        output addr, upper_byte, prefix12, top6, top_nib, low_nib,
        output shift4, shift3, upper_half, tp
    );
endinterface

// *** design/dspdec_fields.sv ***
`timescale 1ns/10ps

module dspdec_fields (
    // Instruction word in, fields out
    dspdec_field_if.split f
);

    ////////////////////////////////////////////////////////////////
    // Field slicing
    assign f.addr = f.word[dspdec_pkg::FLD_ADDR_MSB:dspdec_pkg::FLD_ADDR_LSB];
    assign f.upper_byte = f.word[15:8];
    assign f.prefix12 = f.word[15:4];
    assign f.top6 = f.word[15:10];
    assign f.top_nib = f.word[15:12];
    assign f.low_nib = f.word[dspdec_pkg::FLD_LOWNIB_MSB:0];
    assign f.shift4 = f.word[dspdec_pkg::FLD_SHIFT4_MSB:dspdec_pkg::FLD_SHIFT4_LSB];
    assign f.shift3 = f.word[dspdec_pkg::FLD_SHIFT3_MSB:dspdec_pkg::FLD_SHIFT4_LSB];
    assign f.upper_half = f.word[dspdec_pkg::FLD_HALF_BIT];
    assign f.tp = f.word[dspdec_pkg::FLD_TP_MSB:dspdec_pkg::FLD_TP_LSB];

endmodule

// *** design/dspdec_top.sv ***
`timescale 1ns/10ps

module dspdec_top (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // Fetch side
    input wire logic instr_valid_i,
    input wire logic [15:0] instr_word_i,
    output logic instr_ready_o,
    // Execution side
    input wire logic exec_ready_i,
    input wire logic cond_true_i,
    output logic op_valid_o,
    output dspdec_pkg::dspdec_op_e op_o,
    output logic illegal_o,
    output logic [1:0] words_o,
    output logic [2:0] cycles_o,
    output logic [1:0] pc_inc_o,
    // Operand fields
    output logic [7:0] addr_field_o,
    output logic [7:0] imm8_o,
    output logic [4:0] shift_o,
    output logic upper_half_o,
    output logic [1:0] ret_tp_o,
    output logic [7:0] cond_sel_o,
    output logic [6:0] flag_set_o,
    output logic [15:0] const_o
);

    ////////////////////////////////////////////////////////////////
    // Field extraction
    dspdec_field_if fld ();

    dspdec_fields u_fields (
        .f(fld)
    );

    assign fld.word = instr_word_i;

    ////////////////////////////////////////////////////////////////
    // Sequencer state and handshake
    dspdec_pkg::dspdec_state_e state;
    dspdec_pkg::dspdec_state_e next_state;
    wire take_first;
    wire take_const;

    assign instr_ready_o = exec_ready_i;
    assign take_first = (state == dspdec_pkg::ST_OPCODE) && instr_valid_i && exec_ready_i;
    assign take_const = (state == dspdec_pkg::ST_CONST) && instr_valid_i && exec_ready_i;

    ////////////////////////////////////////////////////////////////
    // Encoding matches
    // full word match for pop, push and xor16; twelve-bit prefix, upper byte, top six bits or top nibble for the rest
    wire is_pop = instr_word_i == dspdec_pkg::ENC_POP;
    wire is_push = instr_word_i == dspdec_pkg::ENC_PUSH;
    wire is_stk_mem = fld.upper_byte == dspdec_pkg::UB_STACK_TO_MEM;
    wire is_mem_stk = fld.upper_byte == dspdec_pkg::UB_MEM_TO_STACK;
    wire is_conditional_return = fld.top6 == dspdec_pkg::TOP6_COND_RET;
    wire is_rpt_imm = fld.upper_byte == dspdec_pkg::UB_RPT_IMM;
    wire is_rpt_mem = fld.upper_byte == dspdec_pkg::UB_RPT_MEM;
    // store nibble, half from bit 11
    wire is_store_acc = fld.top_nib == dspdec_pkg::NIB_STORE_ACC;
    wire is_aux_sub = fld.upper_byte == dspdec_pkg::UB_AUX_SUB;
    wire is_square_accumulate = fld.upper_byte == dspdec_pkg::UB_SQR_ACC;
    wire is_square_subtract = fld.upper_byte == dspdec_pkg::UB_SQR_SUB;
    wire is_store_long_constant = fld.upper_byte == dspdec_pkg::UB_STORE_LONG;
    wire is_sub_long = fld.prefix12 == dspdec_pkg::PFX_SUB_LONG;
    wire is_sub_shift = fld.top_nib == dspdec_pkg::NIB_SUB_SHIFT;
    wire is_sub_borrow = fld.upper_byte == dspdec_pkg::UB_SUB_BORROW;
    wire is_sub_uns = fld.upper_byte == dspdec_pkg::UB_SUB_UNSIGNED;
    wire is_sub_temp = fld.upper_byte == dspdec_pkg::UB_SUB_TEMP;
    wire is_xor_long = fld.prefix12 == dspdec_pkg::PFX_XOR_LONG;
    wire is_xor16 = instr_word_i == dspdec_pkg::ENC_XOR16;
    wire is_clear_load_round = fld.upper_byte == dspdec_pkg::UB_CLR_LOAD_RND;
    wire is_sst0 = fld.upper_byte == dspdec_pkg::UB_STATUS_ZERO;
    wire is_sst1 = fld.upper_byte == dspdec_pkg::UB_STATUS_ONE;
    wire is_spm = (fld.upper_byte == dspdec_pkg::UB_PSHIFT_MODE) && !is_sub_long && !is_xor_long;

    ////////////////////////////////////////////////////////////////
    // Flag set decode
    wire flag_pfx = fld.prefix12 == dspdec_pkg::PFX_FLAG;
    wire [6:0] flag_hot;

    assign flag_hot[dspdec_pkg::FBIT_CARRY] = fld.low_nib == dspdec_pkg::FNIB_CARRY;
    assign flag_hot[dspdec_pkg::FBIT_BLOCK_PROG] = fld.low_nib == dspdec_pkg::FNIB_BLOCK_PROG;
    assign flag_hot[dspdec_pkg::FBIT_INT_DISABLE] = fld.low_nib == dspdec_pkg::FNIB_INT_DISABLE;
    assign flag_hot[dspdec_pkg::FBIT_OVF_MODE] = fld.low_nib == dspdec_pkg::FNIB_OVF_MODE;
    assign flag_hot[dspdec_pkg::FBIT_TEST_CTRL] = fld.low_nib == dspdec_pkg::FNIB_TEST_CTRL;
    assign flag_hot[dspdec_pkg::FBIT_EXT_FLAG] = fld.low_nib == dspdec_pkg::FNIB_EXT_FLAG;
    assign flag_hot[dspdec_pkg::FBIT_SIGN_EXT] = fld.low_nib == dspdec_pkg::FNIB_SIGN_EXT;

    wire is_flag = flag_pfx && (|flag_hot);

    ////////////////////////////////////////////////////////////////
    // Operation select
    dspdec_pkg::dspdec_op_e dec_op;

    assign dec_op =
        is_pop ? dspdec_pkg::OP_POP_TO_ACC :
        is_push ? dspdec_pkg::OP_PUSH_FROM_ACC :
        is_xor16 ? dspdec_pkg::OP_XOR_LONG_SHIFT16 :
        is_flag ? dspdec_pkg::OP_FLAG_SET_GROUP :
        is_sub_long ? dspdec_pkg::OP_ACC_SUBTRACT_LONG :
        is_xor_long ? dspdec_pkg::OP_XOR_LONG_SHIFT :
        is_spm ? dspdec_pkg::OP_PRODUCT_SHIFT_MODE_SET :
        is_stk_mem ? dspdec_pkg::OP_STACK_TO_MEMORY :
        is_mem_stk ? dspdec_pkg::OP_MEMORY_TO_STACK :
        is_conditional_return ? dspdec_pkg::OP_CONDITIONAL_RETURN :
        is_rpt_imm ? dspdec_pkg::OP_REPEAT_NEXT_IMM :
        is_rpt_mem ? dspdec_pkg::OP_REPEAT_NEXT_MEM :
        (is_store_acc && fld.upper_half) ? dspdec_pkg::OP_STORE_UPPER_ACC_SHIFTED :
        is_store_acc ? dspdec_pkg::OP_STORE_LOWER_ACC_SHIFTED :
        is_aux_sub ? dspdec_pkg::OP_AUX_REG_SUBTRACT_IMM :
        is_square_accumulate ? dspdec_pkg::OP_SQUARE_ACCUMULATE :
        is_square_subtract ? dspdec_pkg::OP_SQUARE_SUBTRACT :
        is_store_long_constant ? dspdec_pkg::OP_STORE_LONG_CONSTANT :
        is_sub_shift ? dspdec_pkg::OP_ACC_SUBTRACT_SHIFT :
        is_sub_borrow ? dspdec_pkg::OP_ACC_SUBTRACT_BORROW :
        is_sub_uns ? dspdec_pkg::OP_ACC_SUBTRACT_UNSIGNED :
        is_sub_temp ? dspdec_pkg::OP_ACC_SUBTRACT_TEMP_SHIFT :
        is_clear_load_round ? dspdec_pkg::OP_CLEAR_LOAD_ROUND :
        is_sst0 ? dspdec_pkg::OP_STATUS_STORE_ZERO :
        is_sst1 ? dspdec_pkg::OP_STATUS_STORE_ONE :
        dspdec_pkg::OP_NONE;

    wire dec_illegal = dec_op == dspdec_pkg::OP_NONE;

    ////////////////////////////////////////////////////////////////
    // Word and cycle counts
    // two-word group
    wire two_word = is_store_long_constant || is_sub_long || is_xor_long || is_xor16;
    wire [1:0] dec_words = two_word ? dspdec_pkg::WORDS_TWO : dspdec_pkg::WORDS_ONE;
    wire [2:0] ret_cycles;
    wire [2:0] dec_cycles;

    assign ret_cycles = cond_true_i ? dspdec_pkg::CYC_RET_TAKEN : dspdec_pkg::CYC_RET_SKIP;
    assign dec_cycles = is_conditional_return && !is_flag ? ret_cycles :
                        two_word ? dspdec_pkg::CYC_TWO : dspdec_pkg::CYC_ONE;

    ////////////////////////////////////////////////////////////////
    // Shift amount select
    wire [4:0] dec_shift;

    // low nibble shift for the subtract and xor long prefixes
    assign dec_shift =
        is_xor16 ? dspdec_pkg::SHIFT_XOR16 :
        (is_sub_long || is_xor_long) ? {1'b0, fld.low_nib} :
        is_store_acc ? {2'b00, fld.shift3} :
        is_sub_shift ? {1'b0, fld.shift4} :
        5'h00;

    ////////////////////////////////////////////////////////////////
    // Next state
    // wait for the constant word
    assign next_state = (take_first && two_word) ? dspdec_pkg::ST_CONST :
                        take_const ? dspdec_pkg::ST_OPCODE : state;

    wire next_valid = (take_first && !two_word) || take_const;

    ////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            state <= dspdec_pkg::ST_OPCODE;
            op_valid_o <= 1'b0;
        end else begin
            state <= next_state;
            op_valid_o <= next_valid;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Decoded fields, captured with the first word
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            op_o <= dspdec_pkg::OP_NONE;
            illegal_o <= 1'b0;
            words_o <= dspdec_pkg::WORDS_ONE;
            cycles_o <= dspdec_pkg::CYC_ONE;
            shift_o <= 5'h00;
            upper_half_o <= 1'b0;
            ret_tp_o <= 2'h0;
            flag_set_o <= 7'h00;
        end else if (take_first) begin
            op_o <= dec_op;
            illegal_o <= dec_illegal;
            words_o <= dec_words;
            cycles_o <= dec_cycles;
            shift_o <= dec_shift;
            upper_half_o <= is_store_acc && fld.upper_half;
            ret_tp_o <= fld.tp;
            // flag bits only for the set group
            flag_set_o <= is_flag ? flag_hot : 7'h00;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Address, immediate and condition fields
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            addr_field_o <= 8'h00;
            imm8_o <= 8'h00;
            cond_sel_o <= 8'h00;
        end else if (take_first) begin
            addr_field_o <= fld.addr;
            imm8_o <= fld.addr;
            cond_sel_o <= fld.addr;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Long constant and program counter advance
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            const_o <= 16'h0000;
            pc_inc_o <= 2'h0;
        end else if (take_first) begin
            const_o <= 16'h0000;
            pc_inc_o <= dec_words;
        end else if (take_const) begin
            const_o <= instr_word_i;
        end
    end

endmodule

// *** test/dspdec_props.sv ***
`timescale 1ns/10ps

module dspdec_props (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // Fetch and execution side
    input wire logic instr_valid_i,
    input wire logic [15:0] instr_word_i,
    input wire logic exec_ready_i,
    input wire logic cond_true_i,
    // Decoder outputs
    input wire logic op_valid_o,
    input wire dspdec_pkg::dspdec_op_e op_o,
    input wire logic [1:0] words_o,
    input wire logic [2:0] cycles_o,
    input wire logic [1:0] pc_inc_o,
    input wire logic [7:0] addr_field_o,
    input wire logic [7:0] imm8_o,
    input wire logic [4:0] shift_o,
    input wire logic upper_half_o,
    input wire logic [1:0] ret_tp_o,
    input wire logic [6:0] flag_set_o,
    input wire logic [15:0] const_o
);
    logic take;
    logic first;
    logic two_word;
    logic in_const;

    assign take = instr_valid_i && exec_ready_i;
    assign first = take && !in_const;
    assign two_word = instr_word_i[15:8] == 8'hae || instr_word_i[15:4] == 12'hbfa
        || instr_word_i[15:4] == 12'hbfd || instr_word_i == 16'hbe83;

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            in_const <= 1'b0;
        end else if (take) begin
            in_const <= !in_const && two_word;
        end
    end

    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);

    pop_decode_a: assert property (first && instr_word_i == 16'hbe32 |=>
        op_valid_o && op_o == dspdec_pkg::OP_POP_TO_ACC && words_o == 2'h1 && cycles_o == 3'h1)
        else $error("pop decode wrong");
    push_decode_a: assert property (first && instr_word_i == 16'hbe3c |=>
        op_valid_o && op_o == dspdec_pkg::OP_PUSH_FROM_ACC && pc_inc_o == 2'h1)
        else $error("push decode wrong");
    ret_cycles_a: assert property (first && instr_word_i[15:10] == 6'h3b |=>
        cycles_o == ($past(cond_true_i) ? 3'h4 : 3'h2) && ret_tp_o == $past(instr_word_i[9:8]))
        else $error("conditional return cycles wrong");
    repeat_count_a: assert property (first && instr_word_i[15:8] == 8'hbb |=>
        op_o == dspdec_pkg::OP_REPEAT_NEXT_IMM && imm8_o == $past(instr_word_i[7:0]))
        else $error("repeat count wrong");
    store_half_a: assert property (first && instr_word_i[15:12] == 4'h9 |=>
        upper_half_o == $past(instr_word_i[11]) && shift_o == {2'b00, $past(instr_word_i[10:8])})
        else $error("accumulator store fields wrong");
    flag_onehot_a: assert property (op_valid_o |->
        (op_o == dspdec_pkg::OP_FLAG_SET_GROUP) == $onehot(flag_set_o))
        else $error("flag set vector wrong");
    long_wait_a: assert property (first && two_word |=> !op_valid_o)
        else $error("two-word op answered early");
    addr_pass_a: assert property (first && !two_word |=>
        op_valid_o && addr_field_o == $past(instr_word_i[7:0]))
        else $error("address field not passed");
    const_pair_a: assert property (take && in_const |=>
        op_valid_o && const_o == $past(instr_word_i) && words_o == 2'h2 && pc_inc_o == 2'h2)
        else $error("constant word not paired");
endmodule

bind dspdec_top dspdec_props chk (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .instr_valid_i(instr_valid_i), .instr_word_i(instr_word_i), .exec_ready_i(exec_ready_i),
    .cond_true_i(cond_true_i), .op_valid_o(op_valid_o), .op_o(op_o), .words_o(words_o),
    .cycles_o(cycles_o), .pc_inc_o(pc_inc_o), .addr_field_o(addr_field_o), .imm8_o(imm8_o),
    .shift_o(shift_o), .upper_half_o(upper_half_o), .ret_tp_o(ret_tp_o),
    .flag_set_o(flag_set_o), .const_o(const_o));

// *** test/dspdec_fetch_model.sv ***
`timescale 1ns/10ps

module dspdec_fetch_model (
    // Clock
    input wire logic ref_clk_i,
    // Handshake with decoder
    input wire logic ready_i,
    output logic valid_o = 1'b0,
    output logic [15:0] word_o = 16'h5a5a
);
    logic [15:0] queue [$];
    int gap = 0;
    int wait_n = 0;

    task automatic offer(input logic [15:0] w);
        queue.push_back(w);
    endtask

    always @(posedge ref_clk_i) begin
        if (valid_o && ready_i) begin
            queue.delete(0);
            wait_n = gap;
        end
        if (queue.size() > 0 && wait_n == 0) begin
            valid_o <= 1'b1;
            word_o <= queue[0];
        end else begin
            valid_o <= 1'b0;
            word_o <= ~word_o;
            if (wait_n > 0) begin
                wait_n--;
            end
        end
    end
endmodule

// *** test/dspdec_bench.sv ***
`timescale 1ns/10ps

module dspdec_bench;
    logic ref_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic exec_ready_i = 1'b0;
    logic cond_true_i = 1'b0;
    logic instr_valid_i;
    logic [15:0] instr_word_i;
    logic instr_ready_o, op_valid_o, illegal_o, upper_half_o;
    dspdec_pkg::dspdec_op_e op_o;
    logic [1:0] words_o, pc_inc_o, ret_tp_o;
    logic [2:0] cycles_o;
    logic [7:0] addr_field_o, imm8_o, cond_sel_o;
    logic [4:0] shift_o;
    logic [6:0] flag_set_o;
    logic [15:0] const_o;
    int failures = 0;
    int comparisons = 0;
    int cycles_run = 0;

    always #2.5 ref_clk_i = ~ref_clk_i;

    dspdec_top uut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .instr_valid_i(instr_valid_i),
        .instr_word_i(instr_word_i), .instr_ready_o(instr_ready_o),
        .exec_ready_i(exec_ready_i), .cond_true_i(cond_true_i), .op_valid_o(op_valid_o),
        .op_o(op_o), .illegal_o(illegal_o), .words_o(words_o), .cycles_o(cycles_o),
        .pc_inc_o(pc_inc_o), .addr_field_o(addr_field_o), .imm8_o(imm8_o), .shift_o(shift_o),
        .upper_half_o(upper_half_o), .ret_tp_o(ret_tp_o), .cond_sel_o(cond_sel_o),
        .flag_set_o(flag_set_o), .const_o(const_o));
    dspdec_fetch_model src (.ref_clk_i(ref_clk_i), .ready_i(instr_ready_o),
        .valid_o(instr_valid_i), .word_o(instr_word_i));

    ////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge ref_clk_i) begin
        cycles_run++;
        if (cycles_run == 2000) begin
            failures++;
            close_out();
        end
    end

    task automatic await_op(input dspdec_pkg::dspdec_op_e op, input logic [1:0] wds,
        input logic [2:0] cyc);
        int n;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end while (op_valid_o !== 1'b1 && n < 40);
        check("op_valid", op_valid_o, 16'h1);
        check("op", op_o, op);
        check("illegal", illegal_o, op == dspdec_pkg::OP_NONE);
        check("words", words_o, wds);
        check("pc_inc", pc_inc_o, wds);
        check("cycles", cycles_o, cyc);
    endtask

    ////////////////////////////////////////////////////////////////
    task automatic t_stack();
        src.gap = 2;
        src.offer(16'hbe32);
        src.offer(16'hbe3c);
        src.offer(16'h8a81);
        src.offer(16'h76fe);
        await_op(dspdec_pkg::OP_POP_TO_ACC, 2'h1, 3'h1);
        await_op(dspdec_pkg::OP_PUSH_FROM_ACC, 2'h1, 3'h1);
        await_op(dspdec_pkg::OP_STACK_TO_MEMORY, 2'h1, 3'h1);
        check("addr", addr_field_o, 16'h81);
        await_op(dspdec_pkg::OP_MEMORY_TO_STACK, 2'h1, 3'h1);
        check("addr", addr_field_o, 16'hfe);
        src.gap = 0;
        $display("stack test done");
    endtask

    task automatic t_return();
        @(posedge ref_clk_i);
        cond_true_i <= 1'b1;
        src.offer(16'hed5a);
        await_op(dspdec_pkg::OP_CONDITIONAL_RETURN, 2'h1, 3'h4);
        check("tp", ret_tp_o, 16'h1);
        check("cond", cond_sel_o, 16'h5a);
        @(posedge ref_clk_i);
        cond_true_i <= 1'b0;
        src.offer(16'hee3c);
        await_op(dspdec_pkg::OP_CONDITIONAL_RETURN, 2'h1, 3'h2);
        check("tp", ret_tp_o, 16'h2);
        $display("return test done");
    endtask

    task automatic t_repeat_store();
        src.offer(16'hbb7f);
        src.offer(16'h0b44);
        src.offer(16'h9d21);
        src.offer(16'h9311);
        src.offer(16'h7c80);
        await_op(dspdec_pkg::OP_REPEAT_NEXT_IMM, 2'h1, 3'h1);
        check("imm", imm8_o, 16'h7f);
        await_op(dspdec_pkg::OP_REPEAT_NEXT_MEM, 2'h1, 3'h1);
        check("addr", addr_field_o, 16'h44);
        await_op(dspdec_pkg::OP_STORE_UPPER_ACC_SHIFTED, 2'h1, 3'h1);
        check("upper", upper_half_o, 16'h1);
        check("shift", shift_o, 16'h5);
        await_op(dspdec_pkg::OP_STORE_LOWER_ACC_SHIFTED, 2'h1, 3'h1);
        check("upper", upper_half_o, 16'h0);
        check("shift", shift_o, 16'h3);
        await_op(dspdec_pkg::OP_AUX_REG_SUBTRACT_IMM, 2'h1, 3'h1);
        check("imm", imm8_o, 16'h80);
        $display("repeat and store test done");
    endtask

    task automatic t_flags();
        logic [3:0] nib [7] = '{4'hf, 4'h5, 4'h1, 4'h3, 4'hb, 4'hd, 4'h7};
        for (int i = 0; i < 7; i++) begin
            src.offer({12'hbe4, nib[i]});
        end
        src.offer(16'hbe40);
        for (int i = 0; i < 7; i++) begin
            await_op(dspdec_pkg::OP_FLAG_SET_GROUP, 2'h1, 3'h1);
            check("flags", flag_set_o, 16'h1 << i);
        end
        await_op(dspdec_pkg::OP_NONE, 2'h1, 3'h1);
        check("flags", flag_set_o, 16'h0);
        $display("flag test done");
    endtask

    task automatic t_one_word();
        logic [15:0] w [10] = '{16'h5211, 16'h5322, 16'h3a33, 16'h6444, 16'h6655,
            16'h6766, 16'h6877, 16'h8e88, 16'h8f99, 16'hbf12};
        dspdec_pkg::dspdec_op_e e [10] = '{dspdec_pkg::OP_SQUARE_ACCUMULATE,
            dspdec_pkg::OP_SQUARE_SUBTRACT, dspdec_pkg::OP_ACC_SUBTRACT_SHIFT,
            dspdec_pkg::OP_ACC_SUBTRACT_BORROW, dspdec_pkg::OP_ACC_SUBTRACT_UNSIGNED,
            dspdec_pkg::OP_ACC_SUBTRACT_TEMP_SHIFT, dspdec_pkg::OP_CLEAR_LOAD_ROUND,
            dspdec_pkg::OP_STATUS_STORE_ZERO, dspdec_pkg::OP_STATUS_STORE_ONE,
            dspdec_pkg::OP_PRODUCT_SHIFT_MODE_SET};
        for (int i = 0; i < 10; i++) begin
            src.offer(w[i]);
        end
        for (int i = 0; i < 10; i++) begin
            await_op(e[i], 2'h1, 3'h1);
            check("shift", shift_o, w[i][15:12] == 4'h3 ? w[i][11:8] : 4'h0);
            check("addr", addr_field_o, w[i][7:0]);
        end
        $display("one-word test done");
    endtask

    task automatic t_two_word();
        logic [15:0] w [8] = '{16'hae05, 16'h1234, 16'hbfa7, 16'h8001, 16'hbfdf, 16'hbe32,
            16'hbe83, 16'h00ff};
        dspdec_pkg::dspdec_op_e e [4] = '{dspdec_pkg::OP_STORE_LONG_CONSTANT,
            dspdec_pkg::OP_ACC_SUBTRACT_LONG, dspdec_pkg::OP_XOR_LONG_SHIFT,
            dspdec_pkg::OP_XOR_LONG_SHIFT16};
        logic [4:0] sh [4] = '{5'h0, 5'h7, 5'hf, 5'h10};
        for (int i = 0; i < 8; i++) begin
            src.offer(w[i]);
        end
        src.offer(16'hbe3c);
        for (int i = 0; i < 4; i++) begin
            await_op(e[i], 2'h2, 3'h2);
            check("const", const_o, w[2 * i + 1]);
            check("shift", shift_o, sh[i]);
        end
        check("addr", addr_field_o, 16'h83);
        await_op(dspdec_pkg::OP_PUSH_FROM_ACC, 2'h1, 3'h1);
        check("const", const_o, 16'h0);
        $display("two-word test done");
    endtask

    task automatic t_refuse_reset();
        @(posedge ref_clk_i);
        exec_ready_i <= 1'b0;
        src.offer(16'hbe32);
        repeat (4) begin
            @(posedge ref_clk_i);
            #1;
            check("ready", instr_ready_o, 16'h0);
            check("op_valid", op_valid_o, 16'h0);
        end
        @(posedge ref_clk_i);
        exec_ready_i <= 1'b1;
        await_op(dspdec_pkg::OP_POP_TO_ACC, 2'h1, 3'h1);
        src.offer(16'hae05);
        repeat (3) @(posedge ref_clk_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        #1;
        check("pc_inc", pc_inc_o, 16'h0);
        check("op_valid", op_valid_o, 16'h0);
        @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        src.offer(16'hbe3c);
        await_op(dspdec_pkg::OP_PUSH_FROM_ACC, 2'h1, 3'h1);
        $display("refuse and reset test done");
    endtask

    initial begin
        repeat (2) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        exec_ready_i <= 1'b1;
        t_stack();
        t_return();
        t_repeat_store();
        t_flags();
        t_one_word();
        t_two_word();
        t_refuse_reset();
        close_out();
    end
endmodule
